// *** core/art_timer.sv ***
/*
 * 16-bit prescaled down-counter with pwm, wrap pin, two strobe captures
 * assumes: AXI4-Lite master on sys_clk, strobes asynchronous to sys_clk
 */
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - zero match drives pwm to active level
// - compare match returns pwm to inactive
// - toggle mode inverts pwm on match
// - pwm period from reload or mask
// - wrap pin toggle period is twice (reload plus one)
// - wrap pin cleared by flag, or toggles
// - reload and start on chosen event
// - reload mode: only capture_reg captures
// - strobe a mode: edge reloads, sets flag
// - flag still set at reload: overrun
// - strobe b captures; repeated sets overrun
// - captures resume once flag, overrun clear
// - coincident: capture first, then reload
// - strobe b mode: capture then reload
// - capture only when flag, overrun clear
// - strobe b mode: a only flags
// - first b after reset captures zero
// - run bit restarts, b captures
// - free run wraps to all ones
// - free run: a and b capture apart
// - free run a: capture or overrun
// - free run b: capture or overrun
// - flags always set; irq ors five
// - edge select: 0 falling, 1 rising
// - masked compare ands mask on both
// - software only clears flags
module art_timer (
   // clock, reset, freeze
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // register bus
   input wire art_pkg::art_axi_req_t axiReq,
   output var art_pkg::art_axi_rsp_t axiRsp,
   // strobe pins
   input wire logic strobe_in_a,
   input wire logic strobe_in_b,
   // output pins and interrupt
   output var logic pwm_out_pin,
   output var logic wrap_out_pin,
   output var logic timerIrq
);

   // ********************************
   // helpers
   // ********************************

   // last prescaler count for a select code
   function automatic logic [3:0] preLast(input logic [1:0] psc);
      unique case (psc)
         art_pkg::PSC_OFF: preLast = art_pkg::DIV1_LAST;
         art_pkg::PSC_1: preLast = art_pkg::DIV1_LAST;
         art_pkg::PSC_4: preLast = art_pkg::DIV4_LAST;
         default: preLast = art_pkg::DIV16_LAST;
      endcase
   endfunction

   // merge low two byte lanes into a 16-bit register
   function automatic logic [15:0] wr16(input logic [15:0] old,
         input logic [31:0] d, input logic [3:0] strb);
      wr16 = old;
      if (strb[0]) begin
         wr16[7:0] = d[7:0];
      end
      if (strb[1]) begin
         wr16[15:8] = d[15:8];
      end
   endfunction

   // address decode shared by read and write
   function automatic logic addrOk(input logic [art_pkg::ADDR_W-1:0] a);
      addrOk = (a[1:0] == 2'h0) && (a <= art_pkg::OFF_CNT);
   endfunction

   // selected edge on a synchronised strobe
   function automatic logic edgeSeen(input logic [2:0] sy, input logic rise);
      edgeSeen = rise ? (sy[1] & ~sy[2]) : (~sy[1] & sy[2]);
   endfunction

   // ********************************
   // state
   // ********************************
   art_pkg::art_state_t s_r; // all flops
   art_pkg::art_state_t s_nxt; // next value

   // decoded controls and events
   logic run;
   logic rl;
   logic [1:0] sel;
   logic modeA;
   logic modeB;
   logic tick;
   logic edgeA;
   logic edgeB;
   logic zeroEv;
   logic matchEv;
   logic [4:0] setF;
   logic setOA;
   logic setOB;
   logic [4:0] clrF;
   logic clrOA;
   logic clrOB;
   logic doWr;
   logic [31:0] rdVal;

   // ********************************
   // next state
   // ********************************
   always_comb begin
      s_nxt = s_r;
      run = s_r.ctrl[art_pkg::C_RUN];
      rl = s_r.ctrl[art_pkg::C_RELOAD];
      sel = s_r.ctrl[art_pkg::C_SEL_HI:art_pkg::C_SEL_LO];
      modeA = rl && (sel == art_pkg::SEL_A);
      modeB = rl && (sel == art_pkg::SEL_B);
      setF = '0;
      setOA = 1'b0;
      setOB = 1'b0;
      clrF = '0;
      clrOA = 1'b0;
      clrOB = 1'b0;
      tick = 1'b0;
      zeroEv = 1'b0;
      matchEv = 1'b0;
      rdVal = '0;

      // strobe synchronisers, third stage only for edge detection
      s_nxt.syncA = {s_r.syncA[1:0], strobe_in_a};
      s_nxt.syncB = {s_r.syncB[1:0], strobe_in_b};
      // edges count only while running
      edgeA = run && edgeSeen(s_r.syncA, s_r.ctrl[art_pkg::C_EDGE_A]);
      edgeB = run && edgeSeen(s_r.syncB, s_r.ctrl[art_pkg::C_EDGE_B]);

      // prescaler and down counter
      s_nxt.fresh = 1'b0;
      s_nxt.runD = run;
      if (!run) begin
         // stopped: counter held cleared
         s_nxt.pre = '0;
         s_nxt.cnt = '0;
         s_nxt.started = 1'b0;
      end else begin
         if (s_r.ctrl[art_pkg::C_PSC_HI:art_pkg::C_PSC_LO] != art_pkg::PSC_OFF) begin
            tick = (s_r.pre == preLast(s_r.ctrl[art_pkg::C_PSC_HI:art_pkg::C_PSC_LO]));
            s_nxt.pre = tick ? 4'h0 : 4'(s_r.pre + 4'h1);
         end
         if (s_r.started && tick) begin
            if (s_r.cnt == 16'h0000) begin
               // zero overflow: reload value or wrap to all ones
               s_nxt.cnt = rl ? s_r.rld : art_pkg::ALL_ONES;
               setF[art_pkg::F_WRAP] = 1'b1;
            end else begin
               s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
            end
            s_nxt.fresh = 1'b1;
         end
         // software start on run rising edge
         if (!s_r.runD && !modeA && !modeB) begin
            s_nxt.cnt = rl ? s_r.rld : art_pkg::ALL_ONES;
            s_nxt.started = 1'b1;
            s_nxt.pre = '0;
            s_nxt.fresh = 1'b1;
         end
      end

      // strobe a: flag, overrun and capture or restart
      if (edgeA) begin
         if (!s_r.flg[art_pkg::F_A] && !s_r.ovrA) begin
            setF[art_pkg::F_A] = 1'b1;
            if (!rl) begin
               s_nxt.rld = s_r.cnt;
            end
         end else if (s_r.flg[art_pkg::F_A]) begin
            setOA = 1'b1;
         end
      end
      // strobe b: captures only with flag and overrun clear
      if (edgeB && (!rl || modeB || s_r.started)) begin
         if (!s_r.flg[art_pkg::F_B] && !s_r.ovrB) begin
            // old count stored before any reload below
            s_nxt.cap = s_r.cnt;
            setF[art_pkg::F_B] = 1'b1;
         end else if (s_r.flg[art_pkg::F_B]) begin
            setOB = 1'b1;
         end
      end
      // restart triggers, overriding the count above
      if ((modeA && edgeA) || (modeB && edgeB)) begin
         s_nxt.cnt = s_r.rld;
         s_nxt.started = 1'b1;
         s_nxt.pre = '0;
         s_nxt.fresh = 1'b1;
      end

      // masked compares on each new counter value
      if (run && s_r.fresh) begin
         zeroEv = ((s_r.msk & s_r.cnt) == 16'h0000);
         matchEv = ((s_r.msk & s_r.cnt) == (s_r.msk & s_r.cmp));
      end
      setF[art_pkg::F_ZERO] = zeroEv;
      setF[art_pkg::F_MATCH] = matchEv;

      // pwm pin
      if (!s_r.ctrl[art_pkg::C_PWM_EN]) begin
         s_nxt.pwm = s_r.ctrl[art_pkg::C_PWM_POL];
      end else if (s_r.ctrl[art_pkg::C_PWM_MODE]) begin
         if (matchEv) begin
            s_nxt.pwm = ~s_r.pwm;
         end
      end else begin
         if (zeroEv) begin
            s_nxt.pwm = s_r.ctrl[art_pkg::C_PWM_POL];
         end
         // match wins when both hit together
         if (matchEv) begin
            s_nxt.pwm = ~s_r.ctrl[art_pkg::C_PWM_POL];
         end
      end

      // ********************************
      // register bus
      // ********************************
      // address and data taken independently
      if (axiReq.awvalid && s_r.rsp.awready) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s_r.rsp.wready) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wData = axiReq.wdata;
         s_nxt.wStrb = axiReq.wstrb;
      end
      // response retires on bready
      if (s_r.rsp.bvalid && axiReq.bready) begin
         s_nxt.rsp.bvalid = 1'b0;
      end
      doWr = s_r.awHave && s_r.wHave && !s_r.rsp.bvalid;
      if (doWr) begin
         s_nxt.awHave = 1'b0;
         s_nxt.wHave = 1'b0;
         s_nxt.rsp.bvalid = 1'b1;
         s_nxt.rsp.bresp = addrOk(s_r.awAddr) ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
         unique case (s_r.awAddr)
            art_pkg::OFF_CTRL: begin
               s_nxt.ctrl = art_pkg::CTRL_W'(wr16(16'(s_r.ctrl), s_r.wData, s_r.wStrb));
            end
            art_pkg::OFF_IEN: begin
               if (s_r.wStrb[0]) begin
                  s_nxt.ien = s_r.wData[4:0];
               end
            end
            art_pkg::OFF_FLAG: begin
               // ones clear, zeros leave alone
               if (s_r.wStrb[0]) begin
                  clrF = s_r.wData[4:0];
                  clrOA = s_r.wData[art_pkg::F_OVR_A];
                  clrOB = s_r.wData[art_pkg::F_OVR_B];
               end
            end
            art_pkg::OFF_RLD: begin
               // read only while free running
               if (rl) begin
                  s_nxt.rld = wr16(s_r.rld, s_r.wData, s_r.wStrb);
               end
            end
            art_pkg::OFF_CMP: s_nxt.cmp = wr16(s_r.cmp, s_r.wData, s_r.wStrb);
            art_pkg::OFF_MSK: s_nxt.msk = wr16(s_r.msk, s_r.wData, s_r.wStrb);
            default: begin
               // capture, counter and unmapped: no effect
            end
         endcase
      end

      // read channel, one outstanding
      if (s_r.rsp.rvalid && axiReq.rready) begin
         s_nxt.rsp.rvalid = 1'b0;
         s_nxt.rsp.arready = 1'b1;
      end
      if (axiReq.arvalid && s_r.rsp.arready) begin
         unique case (axiReq.araddr)
            art_pkg::OFF_CTRL: rdVal = 32'(s_r.ctrl);
            art_pkg::OFF_IEN: rdVal = 32'(s_r.ien);
            art_pkg::OFF_FLAG: rdVal = 32'({s_r.ovrB, s_r.ovrA, s_r.flg});
            art_pkg::OFF_RLD: rdVal = 32'(s_r.rld);
            art_pkg::OFF_CMP: rdVal = 32'(s_r.cmp);
            art_pkg::OFF_MSK: rdVal = 32'(s_r.msk);
            art_pkg::OFF_CAP: rdVal = 32'(s_r.cap);
            art_pkg::OFF_CNT: rdVal = 32'(s_r.cnt);
            default: rdVal = '0;
         endcase
         s_nxt.rsp.rvalid = 1'b1;
         s_nxt.rsp.arready = 1'b0;
         s_nxt.rsp.rdata = rdVal;
         s_nxt.rsp.rresp = addrOk(axiReq.araddr) ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
      end
      // ready again only when nothing held
      s_nxt.rsp.awready = !s_nxt.awHave;
      s_nxt.rsp.wready = !s_nxt.wHave;

      // ********************************
      // flags, wrap pin, interrupt
      // ********************************
      // hardware set wins over a clear in the same cycle
      s_nxt.flg = (s_r.flg & ~clrF) | setF;
      s_nxt.ovrA = (s_r.ovrA & ~clrOA) | setOA;
      s_nxt.ovrB = (s_r.ovrB & ~clrOB) | setOB;

      if (!s_r.ctrl[art_pkg::C_WRAP_EN]) begin
         s_nxt.wrapPin = s_r.ctrl[art_pkg::C_WRAP_POL];
      end else if (s_r.ctrl[art_pkg::C_WRAP_MODE]) begin
         if (setF[art_pkg::F_WRAP]) begin
            s_nxt.wrapPin = ~s_r.wrapPin;
         end
      end else begin
         // set mode: pin follows the wrap flag
         s_nxt.wrapPin = s_nxt.flg[art_pkg::F_WRAP] ^ s_r.ctrl[art_pkg::C_WRAP_POL];
      end

      // enable set on a pending flag raises irq at once
      s_nxt.irq = |(s_nxt.flg & s_nxt.ien);
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_r <= art_pkg::ST_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   assign axiRsp = s_r.rsp;
   assign pwm_out_pin = s_r.pwm;
   assign wrap_out_pin = s_r.wrapPin;
   assign timerIrq = s_r.irq;

endmodule

`default_nettype wire

// *** core/art_pkg.sv ***
/*
 * constants, bus carriers and state layout of the reload timer
 * assumes: AXI4-Lite with 32-bit data and byte addresses
 */
package art_pkg;

   // ********************************
   // register map (byte addresses)
   // ********************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;  // control bits
   localparam logic [7:0] OFF_IEN = 8'h04;   // irq enables
   localparam logic [7:0] OFF_FLAG = 8'h08;  // flags, write one clears
   localparam logic [7:0] OFF_RLD = 8'h0C;   // restart_capture_reg
   localparam logic [7:0] OFF_CMP = 8'h10;   // match_value_reg
   localparam logic [7:0] OFF_MSK = 8'h14;   // compare mask
   localparam logic [7:0] OFF_CAP = 8'h18;   // capture_reg, read only
   localparam logic [7:0] OFF_CNT = 8'h1C;   // down_counter_value, read only

   // ********************************
   // control field positions
   // ********************************
   localparam int CTRL_W = 14;
   localparam int C_RUN = 0;        // run_enable_bit
   localparam int C_RELOAD = 1;     // reload enable
   localparam int C_PSC_LO = 2;     // prescaler select, 2 bits
   localparam int C_PSC_HI = 3;
   localparam int C_WRAP_MODE = 4;  // wrap_out_mode
   localparam int C_PWM_MODE = 5;   // pwm_output_mode_sel
   localparam int C_PWM_POL = 6;    // pwm_polarity_sel
   localparam int C_PWM_EN = 7;     // pwm pin enable
   localparam int C_WRAP_EN = 8;    // wrap pin enable
   localparam int C_WRAP_POL = 9;   // wrap pin polarity
   localparam int C_SEL_LO = 10;    // restart_source_sel_lo
   localparam int C_SEL_HI = 11;    // restart_source_sel_hi
   localparam int C_EDGE_A = 12;    // strobe_a_edge_sel
   localparam int C_EDGE_B = 13;    // strobe_b_edge_sel

   // flag / enable positions
   localparam int F_A = 0;
   localparam int F_B = 1;
   localparam int F_WRAP = 2;
   localparam int F_MATCH = 3;
   localparam int F_ZERO = 4;
   localparam int F_OVR_A = 5;
   localparam int F_OVR_B = 6;

   // ********************************
   // codes and counts
   // ********************************
   localparam logic [1:0] SEL_RUN = 2'h0;
   localparam logic [1:0] SEL_A = 2'h1;
   localparam logic [1:0] SEL_B = 2'h2;
   localparam logic [1:0] PSC_OFF = 2'h0;
   localparam logic [1:0] PSC_1 = 2'h1;
   localparam logic [1:0] PSC_4 = 2'h2;
   localparam logic [3:0] DIV1_LAST = 4'h0;
   localparam logic [3:0] DIV4_LAST = 4'h3;
   localparam logic [3:0] DIV16_LAST = 4'hF;
   localparam logic [15:0] ALL_ONES = 16'hFFFF;
   localparam logic [15:0] MASK_RST = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************
   // carriers
   // ********************************
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } art_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } art_axi_rsp_t;

   // whole state of the timer
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [4:0] ien;
      logic [4:0] flg;
      logic ovrA;
      logic ovrB;
      logic [15:0] rld;
      logic [15:0] cmp;
      logic [15:0] msk;
      logic [15:0] cap;
      logic [15:0] cnt;
      logic [3:0] pre;
      logic started;
      logic fresh;
      logic runD;
      logic pwm;
      logic wrapPin;
      logic irq;
      logic [2:0] syncA;
      logic [2:0] syncB;
      logic awHave;
      logic [ADDR_W-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      art_axi_rsp_t rsp;
   } art_state_t;

   localparam art_state_t ST_RST = '{
      msk: MASK_RST,
      rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
      default: '0
   };

endpackage

// *** verification/art_timer_monitor.sv ***
/*
 * port checker for the timer: bus answers, reset state, irq
 * assumes: bound onto art_timer, one clock domain
 */
`timescale 1ns/1ps
`default_nettype none
module art_timer_monitor (
   // clock, reset, freeze
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // register bus
   input wire art_pkg::art_axi_req_t axiReq,
   input wire art_pkg::art_axi_rsp_t axiRsp,
   // pins
   input wire logic strobe_in_a,
   input wire logic strobe_in_b,
   input wire logic pwm_out_pin,
   input wire logic wrap_out_pin,
   input wire logic timerIrq
);
   // ****************
   // checks
   // ****************
   logic wrTake; // address and data taken together
   logic rdTake; // read address taken
   assign wrTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
   assign rdTake = axiReq.arvalid && axiRsp.arready;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_idle_a: assert property ($fell(rst) |-> !pwm_out_pin && !wrap_out_pin && !timerIrq)
      else $error("outputs not idle after reset");
   wr_answer_a: assert property (wrTake |-> ##2 axiRsp.bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (rdTake |=> axiRsp.rvalid && !axiRsp.arready)
      else $error("read answer late");
   b_stands_a: assert property (axiRsp.bvalid && !axiReq.bready
      |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write answer dropped");
   r_stands_a: assert property (axiRsp.rvalid && !axiReq.rready
      |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read answer dropped");
   wr_refused_a: assert property (wrTake && axiReq.awaddr > art_pkg::OFF_CNT
      |-> ##2 axiRsp.bresp == art_pkg::RESP_SLVERR) else $error("bad write accepted");
   rd_refused_a: assert property (rdTake && axiReq.araddr > art_pkg::OFF_CNT
      |=> axiRsp.rresp == art_pkg::RESP_SLVERR && axiRsp.rdata == 32'h0000_0000)
      else $error("bad read accepted");
   irq_masked_a: assert property (wrTake && axiReq.awaddr == art_pkg::OFF_IEN
      && axiReq.wstrb[0] && axiReq.wdata[4:0] == 5'h00 |-> ##4 !timerIrq)
      else $error("irq high with all enables off");
   frozen_a: assert property (!ce |=> $stable(axiRsp) && $stable(pwm_out_pin)
      && $stable(wrap_out_pin) && $stable(timerIrq)) else $error("outputs moved while frozen");
endmodule
`default_nettype wire

// *** verification/art_strobe_load.sv ***
/*
 * far side of the timer: two strobe sources, two pin loads
 * assumes: the bench calls edges() to move a strobe line
 */
`timescale 1ns/1ps
`default_nettype none
module art_strobe_load (
   // clock
   input wire logic sys_clk,
   // strobe lines
   output var logic strobe_in_a = 1'b0,
   output var logic strobe_in_b = 1'b0,
   // loads and their measurements in clocks
   input wire logic pwm_out_pin,
   input wire logic wrap_out_pin,
   output var logic [15:0] pwmPer = 16'h0000,
   output var logic [15:0] pwmHi = 16'h0000,
   output var logic [15:0] wrapPer = 16'h0000
);
   // ****************
   // strobes and loads
   // ****************
   logic pD = 1'b0; // pwm one clock ago
   logic wD = 1'b0; // wrap one clock ago
   logic [15:0] pCnt = 16'h0000; // clocks since pwm rose
   logic [15:0] hCnt = 16'h0000; // clocks pwm high
   logic [15:0] wCnt = 16'h0000; // clocks since wrap rose
   // toggle one strobe n times, each level held long
   task automatic edges(input logic useB, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         if (useB) strobe_in_b <= ~strobe_in_b;
         else strobe_in_a <= ~strobe_in_a;
         repeat (6) @(posedge sys_clk);
      end
   endtask
   // period and high time of the pins, sampled mid-cycle clear of the launching edge
   always @(negedge sys_clk) begin
      pD <= pwm_out_pin;
      wD <= wrap_out_pin;
      pCnt <= (pwm_out_pin && !pD) ? 16'h0001 : pCnt + 16'h0001;
      wCnt <= (wrap_out_pin && !wD) ? 16'h0001 : wCnt + 16'h0001;
      hCnt <= pwm_out_pin ? hCnt + 16'h0001 : 16'h0000;
      if (pwm_out_pin && !pD) pwmPer <= pCnt;
      if (wrap_out_pin && !wD) wrapPer <= wCnt;
      if (!pwm_out_pin && pD) pwmHi <= hCnt;
   end
endmodule
`default_nettype wire

// *** verification/auto_reload_timer_capture_pwm_tb.sv ***
/*
 * bench for the timer: bus tasks and scenario sequence
 * assumes: timer, far side model and checker compiled first
 */
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer_capture_pwm_tb;
   // ****************
   // bench
   // ****************
   logic sys_clk = 1'b0; // 50 MHz
   logic rst = 1'b1;
   logic ce = 1'b1; // low only during the freeze step of the free run test
   logic strA;
   logic strB;
   logic pwm;
   logic wrap;
   logic irq;
   logic [15:0] pwmPer;
   logic [15:0] pwmHi;
   logic [15:0] wrapPer;
   logic [31:0] d; // last read data
   logic [31:0] held; // earlier capture
   logic [31:0] lastResp; // last response code
   int errorCnt = 0;
   int checked = 0;
   int cyc = 0;
   art_pkg::art_axi_req_t req = '0;
   art_pkg::art_axi_rsp_t rsp;
   art_timer dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .axiReq(req), .axiRsp(rsp),
      .strobe_in_a(strA), .strobe_in_b(strB), .pwm_out_pin(pwm), .wrap_out_pin(wrap),
      .timerIrq(irq));
   art_strobe_load far_u (.sys_clk(sys_clk), .strobe_in_a(strA), .strobe_in_b(strB),
      .pwm_out_pin(pwm), .wrap_out_pin(wrap), .pwmPer(pwmPer), .pwmHi(pwmHi),
      .wrapPer(wrapPer));
   initial forever #10 sys_clk = ~sys_clk;
   // run limit
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errorCnt++;
         $display("ERROR %0t: run limit", $time);
         tally_and_finish();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one write, ready sampled before each edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic tA;
      logic tW;
      logic tB;
      @(posedge sys_clk);
      req.awaddr <= a;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      tB = 1'b0;
      while (!tB) begin
         @(negedge sys_clk);
         tA = req.awvalid & rsp.awready;
         tW = req.wvalid & rsp.wready;
         tB = rsp.bvalid;
         lastResp = 32'(rsp.bresp);
         @(posedge sys_clk);
         if (tA) req.awvalid <= 1'b0;
         if (tW) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic tA;
      logic tR;
      @(posedge sys_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      tR = 1'b0;
      while (!tR) begin
         @(negedge sys_clk);
         tA = req.arvalid & rsp.arready;
         tR = rsp.rvalid;
         d = rsp.rdata;
         lastResp = 32'(rsp.rresp);
         @(posedge sys_clk);
         if (tA) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
   endtask
   task automatic rdck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      check(d & m, e);
   endtask
   task automatic flags(input logic [31:0] e);
      rdck(art_pkg::OFF_FLAG, 32'h0000_0063, e);
   endtask
   task automatic nz(input logic [7:0] a);
      rd(a);
      check(32'(d != 32'h0000_0000), 32'h0000_0001);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic done(input string n);
      $display("test %s done", n);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values, refused and ignored accesses
      for (int i = 0; i < 8; i++) begin
         rdck(8'(4 * i), 32'hFFFF_FFFF, (i == 5) ? 32'h0000_FFFF : 32'h0000_0000);
      end
      rd(8'h20);
      check(d, 32'h0000_0000);
      check(lastResp, 32'(art_pkg::RESP_SLVERR));
      wr(8'h21, 32'h0000_0001);
      check(lastResp, 32'(art_pkg::RESP_SLVERR));
      wr(art_pkg::OFF_RLD, 32'h0000_1234);
      rdck(art_pkg::OFF_RLD, 32'hFFFF_FFFF, 32'h0000_0000);
      done("reset");
      // free run: a rising, b falling
      wr(art_pkg::OFF_CTRL, 32'h0000_1005);
      far_u.edges(1'b0, 2);
      flags(32'h0000_0001);
      nz(art_pkg::OFF_RLD);
      held = d;
      far_u.edges(1'b1, 1);
      flags(32'h0000_0001);
      far_u.edges(1'b1, 1);
      flags(32'h0000_0003);
      nz(art_pkg::OFF_CAP);
      far_u.edges(1'b0, 2);
      flags(32'h0000_0023);
      wr(art_pkg::OFF_RLD, 32'h0000_1234);
      rdck(art_pkg::OFF_RLD, 32'hFFFF_FFFF, held);
      @(negedge sys_clk);
      check(32'(irq), 32'h0000_0000);
      wr(art_pkg::OFF_IEN, 32'h0000_0002);
      wait_n(3);
      check(32'(irq), 32'h0000_0001);
      wr(art_pkg::OFF_FLAG, 32'h0000_007F);
      wait_n(3);
      check(32'(irq), 32'h0000_0000);
      rdck(art_pkg::OFF_FLAG, 32'h0000_007F, 32'h0000_0000);
      wr(art_pkg::OFF_IEN, 32'h0000_0000);
      // freeze: counter holds while ce is low
      rd(art_pkg::OFF_CNT);
      held = d;
      ce <= 1'b0;
      repeat (100) @(posedge sys_clk);
      ce <= 1'b1;
      rd(art_pkg::OFF_CNT);
      check(32'((held - d) < 32'h0000_0020), 32'h0000_0001);
      done("free run");
      // pwm and wrap pins, reload 199, compare 4
      wr(art_pkg::OFF_CTRL, 32'h0000_0002);
      wr(art_pkg::OFF_RLD, 32'h0000_00C7);
      wr(art_pkg::OFF_CMP, 32'h0000_0004);
      wr(art_pkg::OFF_CTRL, 32'h0000_01C7);
      wait_n(700);
      check(32'(pwmPer), 32'h0000_00C8);
      check(32'(pwmHi), 32'h0000_00C4);
      check(32'(wrap), 32'h0000_0001);
      @(posedge pwm);
      wr(art_pkg::OFF_FLAG, 32'h0000_0004);
      wait_n(3);
      check(32'(wrap), 32'h0000_0000);
      wr(art_pkg::OFF_CTRL, 32'h0000_01F7);
      wait_n(1300);
      check(32'(pwmPer), 32'h0000_0190);
      check(32'(pwmHi), 32'h0000_00C8);
      check(32'(wrapPer), 32'h0000_0190);
      wr(art_pkg::OFF_MSK, 32'h0000_0007);
      wr(art_pkg::OFF_CTRL, 32'h0000_01C7);
      wait_n(100);
      check(32'(pwmPer), 32'h0000_0008);
      // same mask, prescaler by four
      wr(art_pkg::OFF_CTRL, 32'h0000_01CB);
      wait_n(200);
      check(32'(pwmPer), 32'h0000_0020);
      done("pins");
      // restart on strobe a, captures on b
      wr(art_pkg::OFF_CTRL, 32'h0000_0002);
      wr(art_pkg::OFF_MSK, 32'h0000_FFFF);
      wr(art_pkg::OFF_FLAG, 32'h0000_007F);
      wr(art_pkg::OFF_CTRL, 32'h0000_3407);
      rdck(art_pkg::OFF_CNT, 32'hFFFF_FFFF, 32'h0000_0000);
      far_u.edges(1'b0, 2);
      flags(32'h0000_0001);
      nz(art_pkg::OFF_CNT);
      far_u.edges(1'b0, 2);
      flags(32'h0000_0021);
      far_u.edges(1'b1, 2);
      flags(32'h0000_0023);
      nz(art_pkg::OFF_CAP);
      held = d;
      far_u.edges(1'b1, 2);
      flags(32'h0000_0063);
      rdck(art_pkg::OFF_CAP, 32'hFFFF_FFFF, held);
      rdck(art_pkg::OFF_RLD, 32'hFFFF_FFFF, 32'h0000_00C7);
      wr(art_pkg::OFF_FLAG, 32'h0000_007F);
      far_u.edges(1'b1, 2);
      flags(32'h0000_0002);
      // restart on strobe b from a cleared counter
      wr(art_pkg::OFF_CTRL, 32'h0000_0002);
      wr(art_pkg::OFF_FLAG, 32'h0000_007F);
      wr(art_pkg::OFF_CTRL, 32'h0000_3807);
      far_u.edges(1'b1, 2);
      rdck(art_pkg::OFF_CAP, 32'hFFFF_FFFF, 32'h0000_0000);
      flags(32'h0000_0002);
      far_u.edges(1'b0, 2);
      flags(32'h0000_0003);
      far_u.edges(1'b1, 2);
      flags(32'h0000_0043);
      rdck(art_pkg::OFF_CAP, 32'hFFFF_FFFF, 32'h0000_0000);
      done("restart");
      tally_and_finish();
   end
endmodule
bind art_timer art_timer_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .ce(ce),
   .axiReq(axiReq), .axiRsp(axiRsp), .strobe_in_a(strobe_in_a), .strobe_in_b(strobe_in_b),
   .pwm_out_pin(pwm_out_pin), .wrap_out_pin(wrap_out_pin), .timerIrq(timerIrq));
`default_nettype wire
